// [cfgsr_pkg.sv]
package cfgsr_pkg;
    // ==========================================
    // Register placement
    localparam logic [7:0] CFGSR_STATUS_OFFSET = 8'h06;
    localparam logic [7:0] CFGSR_CAP_PTR_OFFSET = 8'h40;
    localparam int CFGSR_WIDTH = 16;
    // ==========================================
    // Field positions
    localparam int CFGSR_BIT_CAP_LIST = 4;
    localparam int CFGSR_BIT_66MHZ = 5;
    localparam int CFGSR_BIT_UDF = 6;
    localparam int CFGSR_BIT_FAST_B2B = 7;
    localparam int CFGSR_BIT_MDPE = 8;
    localparam int CFGSR_BIT_DEVSEL_LO = 9;
    localparam int CFGSR_BIT_DEVSEL_HI = 10;
    localparam int CFGSR_BIT_STA = 11;
    localparam int CFGSR_BIT_RTA = 12;
    localparam int CFGSR_BIT_RMA = 13;
    localparam int CFGSR_BIT_SSE = 14;
    localparam int CFGSR_BIT_DPE = 15;
    localparam int CFGSR_CMD_BIT_PERR_RESP = 6;
    localparam int CFGSR_NUM_FLAGS = 6;
    // ==========================================
    // Reset and fixed values
    localparam logic CFGSR_RST_CAP_LIST = 1'b1;
    localparam logic CFGSR_RST_66MHZ = 1'b1;
    localparam logic CFGSR_RST_UDF = 1'b0;
    localparam logic CFGSR_FIXED_FAST_B2B = 1'b1;
    localparam logic [1:0] CFGSR_FIXED_DEVSEL = 2'h1;
    localparam logic [3:0] CFGSR_RESERVED_LO = 4'h0;
    localparam logic [5:0] CFGSR_RST_FLAGS = 6'h00;
endpackage : cfgsr_pkg

// [cfgsr_flag.sv]
`timescale 1ns/10ps
// Sticky event flag, cleared by writing 1; a set in the clear cycle wins
module cfgsr_flag (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    typedef struct packed {
        logic flag;
    } cfgsr_flag_state_t;

    cfgsr_flag_state_t st_ff;
    cfgsr_flag_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (set_i) begin
            nxt_st.flag = 1'b1; // [RULE16]
        end else if (clr_i) begin
            nxt_st.flag = 1'b0; // [RULE14]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff <= '0; // [RULE14]
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign flag_o = st_ff.flag;

    property p_set_wins;
        @(posedge clk_i) disable iff (srst_i) (ce_i && set_i) |=> flag_o;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag not set after event"); // [RULE16]

    property p_hold;
        @(posedge clk_i) disable iff (srst_i) (flag_o && !(ce_i && clr_i)) |=> flag_o;
    endproperty
    a_hold: assert property (p_hold) else $error("sticky flag dropped without clear"); // [RULE14]
endmodule : cfgsr_flag

// [cfgsr_events.sv]
`timescale 1ns/10ps
// Qualifies raw bus events into set requests for the sticky flags
module cfgsr_events (
    input wire logic perr_seen_i,
    input wire logic bus_master_i,
    input wire logic perr_resp_en_i,
    input wire logic sig_target_abort_i,
    input wire logic rcv_target_abort_i,
    input wire logic rcv_master_abort_i,
    input wire logic serr_asserted_i,
    input wire logic addr_par_err_i,
    input wire logic tgt_wr_par_err_i,
    input wire logic mst_rd_par_err_i,
    output logic [5:0] set_o
);
    always_comb begin
        set_o = '0;
        set_o[0] = perr_seen_i && bus_master_i && perr_resp_en_i; // [RULE6]
        set_o[1] = sig_target_abort_i; // [RULE8]
        set_o[2] = rcv_target_abort_i; // [RULE9]
        set_o[3] = rcv_master_abort_i; // [RULE10]
        set_o[4] = serr_asserted_i; // [RULE11]
        // Parity detection ignores the response enable on purpose
        set_o[5] = addr_par_err_i || tgt_wr_par_err_i || mst_rd_par_err_i; // [RULE12] [RULE13]
    end
endmodule : cfgsr_events

// [cfgsr_status.sv]
`timescale 1ns/10ps
// Summary of operation
// [RULE1] Bit 4 flags a capability list, resets to 1, first entry at offset 40h.
// [RULE2] Bits 4 and 6 are written only from the local bus, not PCI.
// [RULE3] Bit 5 reports 66 MHz support, resets to 1, local-write only.
// [RULE4] Bit 6 reports user-definable functions and resets to 0.
// [RULE5] Bit 7 always reads 1; writes are ignored.
// [RULE6] Bit 8 sets on PERR while bus master with parity response enabled.
// [RULE7] Bits 10:9 are fixed at 01, medium select timing.
// [RULE8] Bit 11 sets when this device signals a target abort.
// [RULE9] Bit 12 sets when our master transaction receives a target abort.
// [RULE10] Bit 13 sets when our master transaction ends in master abort.
// [RULE11] Bit 14 sets when this device asserts system error.
// [RULE12] Bit 15 sets on parity error even with response disabled.
// [RULE13] Bit 15 sets on address, target-write or master-read parity errors.
// [RULE14] Error flags are sticky, reset to 0, cleared by writing 1.
// [RULE15] Command bit 6 is the parity-error response enable.
// [RULE16] Writing 0 keeps flags; bits 3:0 read zero; set beats clear.
module cfgsr_status (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // PCI configuration access
    input wire logic pci_wr_i,
    input wire logic [7:0] pci_addr_i,
    input wire logic [1:0] pci_be_i,
    input wire logic [15:0] pci_wdata_i,
    // Local bus access
    input wire logic loc_wr_i,
    input wire logic [7:0] loc_addr_i,
    input wire logic [1:0] loc_be_i,
    input wire logic [15:0] loc_wdata_i,
    // Command word from the neighbouring register
    input wire logic [15:0] config_command_word_i,
    // Bus events, one-cycle pulses
    input wire logic perr_seen_i,
    input wire logic bus_master_i,
    input wire logic sig_target_abort_i,
    input wire logic rcv_target_abort_i,
    input wire logic rcv_master_abort_i,
    input wire logic serr_asserted_i,
    input wire logic addr_par_err_i,
    input wire logic tgt_wr_par_err_i,
    input wire logic mst_rd_par_err_i,
    output logic [15:0] config_status_word_o,
    output logic [7:0] cap_ptr_o
);
    // ==========================================
    // State
    typedef struct packed {
        logic cap_list;
        logic mhz66;
        logic udf;
    } cfgsr_status_state_t;

    cfgsr_status_state_t st_ff;
    cfgsr_status_state_t nxt_st;
    logic perr_resp_en;
    logic pci_hit;
    logic loc_hit;
    logic [15:0] clr_mask;
    logic [5:0] flag_set;
    logic [5:0] flag_clr;
    logic [5:0] flags;

    assign perr_resp_en = config_command_word_i[cfgsr_pkg::CFGSR_CMD_BIT_PERR_RESP]; // [RULE15]
    assign pci_hit = pci_wr_i && (pci_addr_i == cfgsr_pkg::CFGSR_STATUS_OFFSET);
    assign loc_hit = loc_wr_i && (loc_addr_i == cfgsr_pkg::CFGSR_STATUS_OFFSET);

    // ==========================================
    // Write-one-to-clear, per byte lane, from either side
    always_comb begin
        clr_mask = '0;
        if (pci_hit) begin
            clr_mask = clr_mask | (pci_wdata_i & {{8{pci_be_i[1]}}, {8{pci_be_i[0]}}});
        end
        if (loc_hit) begin
            clr_mask = clr_mask | (loc_wdata_i & {{8{loc_be_i[1]}}, {8{loc_be_i[0]}}});
        end
    end

    assign flag_clr = {clr_mask[cfgsr_pkg::CFGSR_BIT_DPE], clr_mask[cfgsr_pkg::CFGSR_BIT_SSE],
                       clr_mask[cfgsr_pkg::CFGSR_BIT_RMA], clr_mask[cfgsr_pkg::CFGSR_BIT_RTA],
                       clr_mask[cfgsr_pkg::CFGSR_BIT_STA], clr_mask[cfgsr_pkg::CFGSR_BIT_MDPE]}; // [RULE14]

    cfgsr_events u_events (
        .perr_seen_i(perr_seen_i),
        .bus_master_i(bus_master_i),
        .perr_resp_en_i(perr_resp_en),
        .sig_target_abort_i(sig_target_abort_i),
        .rcv_target_abort_i(rcv_target_abort_i),
        .rcv_master_abort_i(rcv_master_abort_i),
        .serr_asserted_i(serr_asserted_i),
        .addr_par_err_i(addr_par_err_i),
        .tgt_wr_par_err_i(tgt_wr_par_err_i),
        .mst_rd_par_err_i(mst_rd_par_err_i),
        .set_o(flag_set)
    );

    for (genvar g = 0; g < cfgsr_pkg::CFGSR_NUM_FLAGS; g++) begin : g_flag
        cfgsr_flag u_flag (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .ce_i(ce_i),
            .set_i(flag_set[g]),
            .clr_i(flag_clr[g]),
            .flag_o(flags[g])
        );
    end

    // ==========================================
    // Capability bits: local side only, PCI writes ignored
    always_comb begin
        nxt_st = st_ff;
        if (loc_hit && loc_be_i[0]) begin
            nxt_st.cap_list = loc_wdata_i[cfgsr_pkg::CFGSR_BIT_CAP_LIST]; // [RULE2]
            nxt_st.mhz66 = loc_wdata_i[cfgsr_pkg::CFGSR_BIT_66MHZ]; // [RULE3]
            nxt_st.udf = loc_wdata_i[cfgsr_pkg::CFGSR_BIT_UDF]; // [RULE2]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_ff.cap_list <= cfgsr_pkg::CFGSR_RST_CAP_LIST; // [RULE1]
            st_ff.mhz66 <= cfgsr_pkg::CFGSR_RST_66MHZ; // [RULE3]
            st_ff.udf <= cfgsr_pkg::CFGSR_RST_UDF; // [RULE4]
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================
    // Read view
    always_comb begin
        config_status_word_o = '0;
        config_status_word_o[3:0] = cfgsr_pkg::CFGSR_RESERVED_LO; // [RULE16]
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_CAP_LIST] = st_ff.cap_list;
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_66MHZ] = st_ff.mhz66;
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_UDF] = st_ff.udf;
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_FAST_B2B] = cfgsr_pkg::CFGSR_FIXED_FAST_B2B; // [RULE5]
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_MDPE] = flags[0];
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_DEVSEL_HI:cfgsr_pkg::CFGSR_BIT_DEVSEL_LO] =
            cfgsr_pkg::CFGSR_FIXED_DEVSEL; // [RULE7]
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_STA] = flags[1];
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_RTA] = flags[2];
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_RMA] = flags[3];
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_SSE] = flags[4];
        config_status_word_o[cfgsr_pkg::CFGSR_BIT_DPE] = flags[5];
    end

    // Pointer is only meaningful while the capability bit is set
    assign cap_ptr_o = st_ff.cap_list ? cfgsr_pkg::CFGSR_CAP_PTR_OFFSET : 8'h00; // [RULE1]

    // ==========================================
    // Checks
    sequence s_pci_cap_write;
        pci_hit && pci_be_i[0] && !loc_hit && ce_i;
    endsequence

    property p_pci_no_cap_write;
        @(posedge clk_i) disable iff (srst_i) s_pci_cap_write |=> $stable(st_ff);
    endproperty
    a_pci_no_cap_write: assert property (p_pci_no_cap_write) else $error("PCI write changed local bits"); // [RULE2]

    property p_loc_66;
        @(posedge clk_i) disable iff (srst_i) (loc_hit && loc_be_i[0] && ce_i) |=>
            config_status_word_o[5] == $past(loc_wdata_i[5]);
    endproperty
    a_loc_66: assert property (p_loc_66) else $error("local write to 66 MHz bit lost"); // [RULE3]

    property p_fixed_bits;
        @(posedge clk_i) disable iff (srst_i)
            config_status_word_o[10:9] == 2'h1 && config_status_word_o[7] && config_status_word_o[3:0] == 4'h0;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong"); // [RULE5] [RULE7]

    property p_reset_vals;
        @(posedge clk_i) srst_i |=> config_status_word_o == 16'h02B0;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("status reset value wrong"); // [RULE1] [RULE4]

    property p_mdpe_needs_enable;
        @(posedge clk_i) disable iff (srst_i) $rose(flags[0]) |->
            $past(perr_seen_i && bus_master_i && config_command_word_i[6]);
    endproperty
    a_mdpe_needs_enable: assert property (p_mdpe_needs_enable) else $error("master parity flag without cause"); // [RULE6]

    property p_dpe_any;
        @(posedge clk_i) disable iff (srst_i)
            (ce_i && (addr_par_err_i || tgt_wr_par_err_i || mst_rd_par_err_i)) |=> config_status_word_o[15];
    endproperty
    a_dpe_any: assert property (p_dpe_any) else $error("parity detect flag not set"); // [RULE12] [RULE13]

    property p_aborts;
        @(posedge clk_i) disable iff (srst_i)
            (ce_i && sig_target_abort_i && rcv_master_abort_i) |=> config_status_word_o[13] && config_status_word_o[11];
    endproperty
    a_aborts: assert property (p_aborts) else $error("abort flags not set"); // [RULE8] [RULE10]

    property p_clear;
        @(posedge clk_i) disable iff (srst_i)
            (ce_i && flag_clr[4] && !flag_set[4]) |=> !config_status_word_o[14];
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear flag"); // [RULE11] [RULE14]

    property p_rta;
        @(posedge clk_i) disable iff (srst_i) (ce_i && rcv_target_abort_i) |=> config_status_word_o[12];
    endproperty
    a_rta: assert property (p_rta) else $error("received target abort flag not set"); // [RULE9]

    property p_cap_ptr;
        @(posedge clk_i) disable iff (srst_i) cap_ptr_o == (config_status_word_o[4] ? 8'h40 : 8'h00);
    endproperty
    a_cap_ptr: assert property (p_cap_ptr) else $error("capability pointer mismatch"); // [RULE1]

    // ==========================================
    // Per-flag and local-only bit checks
    property p_ce_freeze;
        @(posedge clk_i) disable iff (srst_i) !ce_i |=> $stable(config_status_word_o);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("status moved with enable low"); // [RULE14]

    property p_loc_cap;
        @(posedge clk_i) disable iff (srst_i) (loc_hit && loc_be_i[0] && ce_i) |=>
            config_status_word_o[4] == $past(loc_wdata_i[4]);
    endproperty
    a_loc_cap: assert property (p_loc_cap) else $error("local write to capability bit lost"); // [RULE2]

    property p_loc_udf;
        @(posedge clk_i) disable iff (srst_i) (loc_hit && loc_be_i[0] && ce_i) |=>
            config_status_word_o[6] == $past(loc_wdata_i[6]);
    endproperty
    a_loc_udf: assert property (p_loc_udf) else $error("local write to user bit lost"); // [RULE2] [RULE4]

    property p_cap_lane_hold;
        @(posedge clk_i) disable iff (srst_i) !(loc_hit && loc_be_i[0]) |=> $stable(config_status_word_o[6:4]);
    endproperty
    a_cap_lane_hold: assert property (p_cap_lane_hold) else $error("local-only bits moved"); // [RULE2] [RULE3]

    property p_mdpe_set;
        @(posedge clk_i) disable iff (srst_i)
            (ce_i && perr_seen_i && bus_master_i && config_command_word_i[6]) |=> config_status_word_o[8];
    endproperty
    a_mdpe_set: assert property (p_mdpe_set) else $error("master parity flag not set"); // [RULE6]

    property p_mdpe_off;
        @(posedge clk_i) disable iff (srst_i)
            (!config_status_word_o[8] && !config_command_word_i[6]) |=> !config_status_word_o[8];
    endproperty
    a_mdpe_off: assert property (p_mdpe_off) else $error("master parity flag with response off"); // [RULE6] [RULE15]

    property p_mdpe_not_master;
        @(posedge clk_i) disable iff (srst_i)
            (!config_status_word_o[8] && !bus_master_i) |=> !config_status_word_o[8];
    endproperty
    a_mdpe_not_master: assert property (p_mdpe_not_master) else $error("master parity flag as target"); // [RULE6]

    property p_sta_set;
        @(posedge clk_i) disable iff (srst_i) (ce_i && sig_target_abort_i) |=> config_status_word_o[11];
    endproperty
    a_sta_set: assert property (p_sta_set) else $error("signaled abort flag not set"); // [RULE8]

    property p_rma_set;
        @(posedge clk_i) disable iff (srst_i) (ce_i && rcv_master_abort_i) |=> config_status_word_o[13];
    endproperty
    a_rma_set: assert property (p_rma_set) else $error("master abort flag not set"); // [RULE10]

    property p_sse_set;
        @(posedge clk_i) disable iff (srst_i) (ce_i && serr_asserted_i) |=> config_status_word_o[14];
    endproperty
    a_sse_set: assert property (p_sse_set) else $error("system error flag not set"); // [RULE11]

    property p_dpe_no_enable;
        @(posedge clk_i) disable iff (srst_i)
            (ce_i && addr_par_err_i && !config_command_word_i[6]) |=> config_status_word_o[15];
    endproperty
    a_dpe_no_enable: assert property (p_dpe_no_enable) else $error("parity detect needs enable"); // [RULE12]

    sequence s_serr_event;
        ce_i && serr_asserted_i;
    endsequence

    sequence s_serr_clear;
        ce_i && pci_hit && pci_be_i[1] && pci_wdata_i[14] && !serr_asserted_i;
    endsequence

    property p_serr_walk;
        @(posedge clk_i) disable iff (srst_i) s_serr_event ##1 s_serr_clear |=> !config_status_word_o[14];
    endproperty
    a_serr_walk: assert property (p_serr_walk) else $error("system error flag survived clear"); // [RULE11] [RULE14]

    sequence s_flag_zero_write;
        ce_i && pci_hit && pci_be_i[1] && pci_wdata_i[15:11] == 5'h00 && !loc_hit;
    endsequence

    property p_zero_keeps;
        @(posedge clk_i) disable iff (srst_i) s_flag_zero_write |=>
            (config_status_word_o[15:11] & $past(config_status_word_o[15:11])) == $past(config_status_word_o[15:11]);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("writing zero dropped a flag"); // [RULE16]

    sequence s_loc_dpe_clear;
        ce_i && loc_hit && loc_be_i[1] && loc_wdata_i[15];
    endsequence

    property p_loc_dpe_clear;
        @(posedge clk_i) disable iff (srst_i)
            (s_loc_dpe_clear ##0 !(addr_par_err_i || tgt_wr_par_err_i || mst_rd_par_err_i)) |=>
            !config_status_word_o[15];
    endproperty
    a_loc_dpe_clear: assert property (p_loc_dpe_clear) else $error("local clear of parity flag lost"); // [RULE14]

    property p_mdpe_clear;
        @(posedge clk_i) disable iff (srst_i)
            (ce_i && loc_hit && loc_be_i[1] && loc_wdata_i[8] && !perr_seen_i) |=> !config_status_word_o[8];
    endproperty
    a_mdpe_clear: assert property (p_mdpe_clear) else $error("master parity flag not cleared"); // [RULE14]

    property p_flag_lane;
        @(posedge clk_i) disable iff (srst_i) (ce_i && pci_hit && !pci_be_i[1] && !loc_hit) |=>
            (config_status_word_o[15:11] & $past(config_status_word_o[15:11])) == $past(config_status_word_o[15:11]);
    endproperty
    a_flag_lane: assert property (p_flag_lane) else $error("disabled lane cleared a flag"); // [RULE14]
endmodule : cfgsr_status

// [cfgsr_agent.sv]
`timescale 1ns/10ps
// ==========================================
// Far side: configuration host and bus agents, one registered cycle per request
module cfgsr_agent (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_wr_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [1:0] req_be_i,
    input wire logic [15:0] req_data_i,
    input wire logic [7:0] req_ev_i,
    output logic pci_wr_o,
    output logic [7:0] pci_addr_o,
    output logic [1:0] pci_be_o,
    output logic [15:0] pci_wdata_o,
    output logic [7:0] ev_o
);
    always @(posedge clk_i) begin
        pci_wr_o <= req_wr_i && !srst_i;
        ev_o <= srst_i ? 8'h00 : req_ev_i;
        if (srst_i) begin
            pci_addr_o <= 8'h00;
            pci_be_o <= 2'h0;
            pci_wdata_o <= 16'h0000;
        end else if (req_wr_i) begin
            // Ones clear flags, zeros leave them alone
            pci_addr_o <= req_addr_i;
            pci_be_o <= req_be_i;
            pci_wdata_o <= req_data_i;
        end else begin
            // Released bus must not hold its last value
            pci_addr_o <= ~pci_addr_o;
            pci_be_o <= ~pci_be_o;
            pci_wdata_o <= ~pci_wdata_o;
        end
    end
endmodule : cfgsr_agent

// [pci_config_status_register_bench.sv]
`timescale 1ns/10ps
module pci_config_status_register_bench;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic req_wr = 1'b0;
    logic [7:0] req_addr = 8'h06;
    logic [1:0] req_be = 2'h3;
    logic [15:0] req_data = 16'h0000;
    logic [7:0] req_ev = 8'h00;
    logic loc_wr = 1'b0;
    logic [7:0] loc_addr = 8'h06;
    logic [1:0] loc_be = 2'h3;
    logic [15:0] loc_wdata = 16'h0000;
    logic [15:0] cmd_word = 16'h0040;
    logic bus_master = 1'b1;
    logic pci_wr;
    logic [7:0] pci_addr;
    logic [1:0] pci_be;
    logic [15:0] pci_wdata;
    logic [7:0] ev;
    logic [15:0] status;
    logic [7:0] cap_ptr;
    logic [15:0] exp_ff;
    logic chk_on = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 92;
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    cfgsr_agent agent (.clk_i(clk_i), .srst_i(srst_i), .req_wr_i(req_wr), .req_addr_i(req_addr),
        .req_be_i(req_be), .req_data_i(req_data), .req_ev_i(req_ev), .pci_wr_o(pci_wr),
        .pci_addr_o(pci_addr), .pci_be_o(pci_be), .pci_wdata_o(pci_wdata), .ev_o(ev));
    cfgsr_status uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .pci_wr_i(pci_wr),
        .pci_addr_i(pci_addr), .pci_be_i(pci_be), .pci_wdata_i(pci_wdata), .loc_wr_i(loc_wr),
        .loc_addr_i(loc_addr), .loc_be_i(loc_be), .loc_wdata_i(loc_wdata),
        .config_command_word_i(cmd_word), .perr_seen_i(ev[0]), .bus_master_i(bus_master),
        .sig_target_abort_i(ev[1]), .rcv_target_abort_i(ev[2]), .rcv_master_abort_i(ev[3]),
        .serr_asserted_i(ev[4]), .addr_par_err_i(ev[5]), .tgt_wr_par_err_i(ev[6]),
        .mst_rd_par_err_i(ev[7]), .config_status_word_o(status), .cap_ptr_o(cap_ptr));
    // ==========================================
    // Reference model, fed from the inputs the design really sees
    function automatic logic [15:0] nxt_exp(input logic [15:0] cur);
        logic [15:0] clr;
        logic [15:0] set;
        logic [15:0] r;
        clr = 16'h0000;
        if (pci_wr && pci_addr == cfgsr_pkg::CFGSR_STATUS_OFFSET && pci_be[1]) clr = pci_wdata;
        if (loc_wr && loc_addr == cfgsr_pkg::CFGSR_STATUS_OFFSET && loc_be[1]) clr = clr | loc_wdata;
        clr = clr & 16'hF900;
        set = {ev[5] | ev[6] | ev[7], ev[4], ev[3], ev[2], ev[1], 2'h0, ev[0] & bus_master & cmd_word[6], 8'h00};
        r = (cur & ~clr) | set;
        if (loc_wr && loc_addr == cfgsr_pkg::CFGSR_STATUS_OFFSET && loc_be[0]) r[6:4] = loc_wdata[6:4];
        return r;
    endfunction : nxt_exp
    always @(posedge clk_i) begin
        if (srst_i) exp_ff <= 16'h02B0;
        else if (ce_i) exp_ff <= nxt_exp(exp_ff);
    end
    always @(negedge clk_i) begin
        if (chk_on) begin
            tests_run++;
            if (status !== exp_ff) begin
                error_cnt++;
                $display("[FAIL] t=%0t status got %h exp %h", $time, status, exp_ff);
            end
            tests_run++;
            if (cap_ptr !== (exp_ff[4] ? 8'h40 : 8'h00)) begin
                error_cnt++;
                $display("[FAIL] t=%0t cap_ptr got %h exp %h", $time, cap_ptr, exp_ff[4] ? 8'h40 : 8'h00);
            end
        end
    end
    // ==========================================
    // Stimulus
    task automatic put(input logic pw, input logic [15:0] pd, input logic lw, input logic [15:0] ld,
        input logic [7:0] e);
        @(posedge clk_i);
        req_wr <= pw;
        req_addr <= 8'h06;
        req_be <= 2'h3;
        req_data <= pd;
        loc_wr <= lw;
        loc_addr <= 8'h06;
        loc_be <= 2'h3;
        loc_wdata <= ld;
        req_ev <= e;
    endtask : put
    task automatic rnd_cycle(input logic rst);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        a = $random(seed);
        b = $random(seed);
        c = $random(seed);
        @(posedge clk_i);
        srst_i <= rst;
        req_wr <= a[1:0] == 2'h0;
        req_addr <= a[2] ? 8'h06 : b[31:24];
        req_be <= a[4:3];
        req_data <= b[15:0];
        req_ev <= a[15:8] & a[23:16] & a[31:24];
        ce_i <= a[7:5] != 3'h0;
        loc_wr <= c[1:0] == 2'h0;
        loc_addr <= c[2] ? 8'h06 : c[31:24];
        loc_be <= c[4:3];
        loc_wdata <= c[23:8];
        cmd_word <= b[31:16];
        bus_master <= c[5];
    endtask : rnd_cycle
    task automatic close_out();
        $display("mismatches %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    initial begin
        #(8 * 20000);
        error_cnt++;
        close_out();
    end
    initial begin
        @(posedge clk_i);
        chk_on = 1'b1;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        put(1'b0, 16'h0000, 1'b0, 16'h0000, 8'h00);
        put(1'b1, 16'hFFFF, 1'b0, 16'h0000, 8'h00);
        put(1'b0, 16'h0000, 1'b1, 16'h0000, 8'h00);
        put(1'b0, 16'h0000, 1'b1, 16'hFFFF, 8'h00);
        put(1'b0, 16'h0000, 1'b0, 16'h0000, 8'hFF);
        put(1'b1, 16'hFFFF, 1'b0, 16'h0000, 8'hFF);
        put(1'b1, 16'h0000, 1'b1, 16'h0000, 8'h00);
        put(1'b1, 16'hFFFF, 1'b1, 16'hFFFF, 8'h00);
        // Each event alone, then a one-hot write to status bit 8+k[2:0]; second pass without parity response
        for (int k = 0; k < 16; k++) begin
            cmd_word <= k < 8 ? 16'h0040 : 16'hFFBF;
            put(1'b0, 16'h0000, 1'b0, 16'h0000, 8'h01 << k[2:0]);
            put(1'b0, 16'h0000, 1'b0, 16'h0000, 8'h00);
            put(1'b1, 16'h0100 << k[2:0], 1'b0, 16'h0000, 8'h00);
        end
        for (int i = 0; i < 3000; i++) rnd_cycle(i >= 1500 && i < 1502);
        put(1'b0, 16'h0000, 1'b0, 16'h0000, 8'h00);
        repeat (2) @(posedge clk_i);
        close_out();
    end
endmodule : pci_config_status_register_bench
